// ===== core/serial_flash_command_hold.v
/*
 * Serial flash command front end with pause (hold) support, plus the
 * read-data FIFO that feeds its output shifter.
 * Assumes all pins are asynchronous to clk_i and that clk_i runs much faster
 * than the serial clock; the pad ring resolves io levels from io_oe_n_o.
 */
`timescale 1ns/1ns
`include "sflash_consts.vh"

module sf_byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             rstn_i,
  input  wire             flush_i,
  // fill side
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  // drain side
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wp_q;
  reg [AW-1:0]    rp_q;
  reg [AW:0]      cnt_q;
  wire            push = in_valid_i & in_ready_o;
  wire            pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (cnt_q != DEPTH[AW:0]) & ~flush_i;
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o  = mem_q[rp_q];

  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      if (push & ~pop) cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// Notes on behaviour
// R1: pause freezes the serial interface only; executor keeps running.
// R2: pause starts with chip select low, pause low and serial clock low.
// R3: pause ends once pause input is high and serial clock is low.
// R4: data output lanes float whenever the pause input is low outside four-line mode.
// R5: serial clock edges and input data are ignored while paused.
// R6: chip select rising during a pause abandons the command silently.
// R7: host must hold pause high and select low before a new command.
// R8: pause input is ignored while four-line mode is selected.
// R9: six read opcodes, three address bytes, all but normal read add dummies.
// R10: reads stream bytes until deselect; quad address/data read has six dummies.
// R11: per-read lane widths for address and data phases.
// R12: program, sector erase and block erase opcodes each take three address bytes.
// R13: chip erase accepted under two opcodes, no address.
// R14: parameter-table read takes three address bytes and one dummy byte.
// R15: one opcode sets and one clears the write enable latch.
// R16: status and config reads; combined write takes two value bytes.
// R17: two suspend opcodes and two resume opcodes are passed to the executor.
// R18: deep sleep opcode, and burst length set with one value byte.
// R19: sample on rising serial clock, drive on falling; modes 0 and 3.
// R20: unknown opcode floats output and ignores the bus until next select.
// R21: write-type commands execute only if deselect lands on a byte boundary.
// R22: array commands are ignored while the executor is busy.
// R23: everything moves most significant bit first, address high byte first.
module serial_flash_command_hold (
  // clock and reset
  input  wire        clk_i,
  input  wire        rstn_i,
  // serial pins
  input  wire        cs_n_i,
  input  wire        sclk_i,
  input  wire        hold_n_i,
  input  wire [3:0]  io_i,
  output wire [3:0]  io_o,
  output wire [3:0]  io_oe_n_o,
  // configuration and executor status
  input  wire        quad_mode_i,
  input  wire        busy_i,
  input  wire        wel_clr_i,
  input  wire [7:0]  status_i,
  input  wire [7:0]  config_i,
  output wire        write_enable_latch_o,
  output wire [7:0]  burst_len_o,
  output wire        hold_o,
  // command issue to the executor
  output wire        exec_valid_o,
  output wire [7:0]  exec_op_o,
  output wire [23:0] addr_o,
  output wire [7:0]  val0_o,
  output wire [7:0]  val1_o,
  // program data bytes
  output wire [7:0]  wr_data_o,
  output wire        wr_valid_o,
  // array read request and data
  output wire        rd_req_o,
  output wire        rd_param_o,
  input  wire [7:0]  rd_data_i,
  input  wire        rd_valid_i,
  output wire        rd_ready_o
);
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_ADDR  = 3'h1;
  localparam [2:0] S_DUMMY = 3'h2;
  localparam [2:0] S_OUT   = 3'h3;
  localparam [2:0] S_IN    = 3'h4;
  localparam [2:0] S_END   = 3'h5;
  localparam [2:0] S_STBY  = 3'h6;

  // pins: hold, cs, sclk, io[3:0]
  reg  [6:0]  s1_q;
  reg  [6:0]  s2_q;
  reg         sclk_d_q;
  reg         cs_n_d_q;
  wire        hold_n_s = s2_q[6];
  wire        cs_n_s   = s2_q[5];
  wire        sclk_s   = s2_q[4];
  wire [3:0]  io_s     = s2_q[3:0];

  reg  [2:0]  st_q;
  reg  [2:0]  pos_q;
  reg  [3:0]  cnt_q;
  reg  [2:0]  lanes_q;
  reg  [7:0]  sh_q;
  reg  [7:0]  op_q;
  reg  [23:0] addr_q;
  reg  [2:0]  dl_q;
  reg  [3:0]  dum_q;
  reg         rd_q;
  reg         reg_q;
  reg         prog_q;
  reg  [3:0]  nval_q;
  reg         hold_q;
  reg         drive_q;
  reg  [7:0]  out_sh_q;
  reg  [3:0]  io_q;
  reg         wel_q;
  reg  [7:0]  burst_q;
  reg         exec_q;
  reg  [7:0]  val0_q;
  reg  [7:0]  val1_q;
  reg  [7:0]  wr_data_q;
  reg         wr_valid_q;
  reg         rd_req_q;

  // sampling edges are dropped while paused
  wire        live  = ~cs_n_s & ~hold_q;                         // see R5
  wire        rise  = live & sclk_s & ~sclk_d_q;                 // see R19
  wire        fall  = live & ~sclk_s & sclk_d_q;                 // see R19
  wire [2:0]  pos_nx = pos_q + lanes_q;
  wire        byte_done = (pos_nx == `POS_ZERO);

  // msb first on every lane count
  reg  [7:0]  in_byte;
  always @* begin
    case (lanes_q)
      `LANES_2: in_byte = {sh_q[5:0], io_s[1:0]};
      `LANES_4: in_byte = {sh_q[3:0], io_s[3:0]};
      default:  in_byte = {sh_q[6:0], io_s[0]};               // see R23
    endcase
  end

  // opcode decode
  reg         d_ok;
  reg         d_addr;
  reg         d_rd;
  reg         d_reg;
  reg         d_prog;
  reg         d_arr;
  reg  [2:0]  d_al;
  reg  [2:0]  d_dl;
  reg  [3:0]  d_dum;
  reg  [3:0]  d_nval;
  always @* begin
    d_ok = 1'b1; d_addr = 1'b0; d_rd = 1'b0; d_reg = 1'b0; d_prog = 1'b0;
    d_arr = 1'b0; d_al = `LANES_1; d_dl = `LANES_1; d_dum = `DUMMY_NONE;
    d_nval = `VAL_NONE;
    case (in_byte)                                               // see R9
      `OP_NORMAL_READ: begin d_addr = 1'b1; d_rd = 1'b1; d_arr = 1'b1; end
      `OP_FAST_READ: begin
        d_addr = 1'b1; d_rd = 1'b1; d_arr = 1'b1; d_dum = `DUMMY_FAST;
      end
      `OP_DUAL_ADDR_DATA_READ: begin                             // see R11
        d_addr = 1'b1; d_rd = 1'b1; d_arr = 1'b1; d_dum = `DUMMY_DUAL_IO;
        d_al = `LANES_2; d_dl = `LANES_2;
      end
      `OP_DUAL_OUTPUT_READ: begin
        d_addr = 1'b1; d_rd = 1'b1; d_arr = 1'b1; d_dum = `DUMMY_FAST;
        d_dl = `LANES_2;
      end
      `OP_QUAD_ADDR_DATA_READ: begin                             // see R10
        d_addr = 1'b1; d_rd = 1'b1; d_arr = 1'b1; d_dum = `DUMMY_QUAD_IO;
        d_al = `LANES_4; d_dl = `LANES_4;
      end
      `OP_QUAD_OUTPUT_READ: begin
        d_addr = 1'b1; d_rd = 1'b1; d_arr = 1'b1; d_dum = `DUMMY_FAST;
        d_dl = `LANES_4;
      end
      `OP_PARAM_TABLE_READ: begin                                // see R14
        d_addr = 1'b1; d_rd = 1'b1; d_dum = `DUMMY_PARAM;
      end
      `OP_PAGE_PROGRAM: begin d_addr = 1'b1; d_prog = 1'b1; d_arr = 1'b1; end
      `OP_QUAD_PAGE_PROGRAM: begin                               // see R12
        d_addr = 1'b1; d_prog = 1'b1; d_arr = 1'b1;
        d_al = `LANES_4; d_dl = `LANES_4;
      end
      `OP_SECTOR_ERASE_4K, `OP_BLOCK_ERASE_32K, `OP_BLOCK_ERASE_64K: begin
        d_addr = 1'b1; d_arr = 1'b1;
      end
      `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: d_arr = 1'b1;          // see R13
      `OP_STATUS_READ, `OP_CONFIG_READ: d_reg = 1'b1;            // see R16
      `OP_STATUS_CONFIG_WRITE: d_nval = `VAL_STATUS_CONFIG;
      `OP_BURST_LENGTH_SET: d_nval = `VAL_BURST;                 // see R18
      `OP_SET_WRITE_LATCH, `OP_CLEAR_WRITE_LATCH, `OP_DEEP_SLEEP_ENTRY,
      `OP_SUSPEND_A, `OP_SUSPEND_B, `OP_RESUME_A, `OP_RESUME_B: d_ok = 1'b1; // see R17
      default: d_ok = 1'b0;                                      // see R20
    endcase
  end

  // output byte source: register value repeats, array data comes buffered
  wire [7:0]  fifo_data;
  wire        fifo_valid;
  wire        out_load = fall & (st_q == S_OUT) & (pos_q == `POS_ZERO);
  wire        fifo_pop = out_load & rd_q;
  wire [7:0]  reg_byte = (op_q == `OP_CONFIG_READ) ? config_i : status_i;
  wire [7:0]  rd_byte  = fifo_valid ? fifo_data : `BYTE_RST;
  wire [7:0]  nb = out_load ? (reg_q ? reg_byte : rd_byte) : out_sh_q;

  sf_byte_fifo #(
    .WIDTH (`RDBUF_WIDTH),
    .DEPTH (`RDBUF_DEPTH),
    .AW    (`RDBUF_AW)
  ) u_rdbuf (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .flush_i     (cs_n_s),
    .in_data_i   (rd_data_i),
    .in_valid_i  (rd_valid_i),
    .in_ready_o  (rd_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  // the early pause check uses the synced pin so lanes float at once
  wire        pause_pin = ~hold_n_s & ~quad_mode_i;              // see R8
  wire [3:0]  lane_mask = (dl_q == `LANES_4) ? 4'hf :
                          (dl_q == `LANES_2) ? 4'h3 : 4'h2;
  wire        drive_en  = drive_q & ~cs_n_s & ~hold_q & ~pause_pin; // see R4
  assign io_oe_n_o = ~(lane_mask & {4{drive_en}});
  assign io_o      = io_q;

  wire        end_ok = (st_q == S_END) |
                       ((st_q == S_IN) & prog_q & (pos_q == `POS_ZERO) &
                        (cnt_q != `CNT_ZERO));

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= 7'h7f; s2_q <= 7'h7f; sclk_d_q <= 1'b0; cs_n_d_q <= 1'b1;
      st_q <= S_IDLE; pos_q <= `POS_ZERO; cnt_q <= `CNT_ZERO;
      lanes_q <= `LANES_1; sh_q <= `BYTE_RST; op_q <= `BYTE_RST;
      addr_q <= `ADDR_RST; dl_q <= `LANES_1;
      dum_q <= `DUMMY_NONE; rd_q <= 1'b0; reg_q <= 1'b0; prog_q <= 1'b0;
      nval_q <= `VAL_NONE; hold_q <= 1'b0; drive_q <= 1'b0;
      out_sh_q <= `BYTE_RST; io_q <= 4'h0; wel_q <= 1'b0;
      burst_q <= `BURST_LEN_RST; exec_q <= 1'b0; val0_q <= `BYTE_RST;
      val1_q <= `BYTE_RST; wr_data_q <= `BYTE_RST; wr_valid_q <= 1'b0;
      rd_req_q <= 1'b0;
    end else begin
      s1_q <= {hold_n_i, cs_n_i, sclk_i, io_i};
      s2_q <= s1_q;
      sclk_d_q <= sclk_s;
      cs_n_d_q <= cs_n_s;
      exec_q <= 1'b0;
      wr_valid_q <= 1'b0;
      rd_req_q <= 1'b0;
      // level form of the pause gives the deferral while sclk is high
      if (cs_n_s | quad_mode_i) hold_q <= 1'b0;                  // see R8
      else if (!sclk_s) hold_q <= ~hold_n_s;                     // see R2 R3
      if (wel_clr_i) wel_q <= 1'b0;
      if (cs_n_s) begin
        // executor keeps running; only interface state is dropped
        if (!cs_n_d_q && !hold_q && end_ok) begin                // see R1 R6 R21
          exec_q <= 1'b1;
          if (op_q == `OP_SET_WRITE_LATCH) wel_q <= 1'b1;        // see R15
          if (op_q == `OP_CLEAR_WRITE_LATCH) wel_q <= 1'b0;
          if (op_q == `OP_BURST_LENGTH_SET) burst_q <= val0_q;   // see R18
        end
        st_q <= S_IDLE; pos_q <= `POS_ZERO; cnt_q <= `CNT_ZERO;
        lanes_q <= `LANES_1; drive_q <= 1'b0;
      end else if (rise) begin
        sh_q <= in_byte;
        pos_q <= pos_nx;
        case (st_q)
          S_IDLE: if (byte_done) begin
            op_q <= in_byte; dl_q <= d_dl; dum_q <= d_dum;
            rd_q <= d_rd; reg_q <= d_reg; prog_q <= d_prog; nval_q <= d_nval;
            cnt_q <= `CNT_ZERO;
            if (!d_ok || (d_arr && busy_i)) st_q <= S_STBY;      // see R20 R22
            else if (d_addr) begin st_q <= S_ADDR; lanes_q <= d_al; end
            else if (d_reg) begin st_q <= S_OUT; lanes_q <= d_dl; end
            else if (d_nval != `VAL_NONE) st_q <= S_IN;
            else st_q <= S_END;
          end
          S_ADDR: if (byte_done) begin
            addr_q <= {addr_q[15:0], in_byte};                   // see R23
            cnt_q <= cnt_q + `CNT_ONE;
            if (cnt_q == `ADDR_LAST) begin
              cnt_q <= `CNT_ZERO;
              rd_req_q <= rd_q;
              lanes_q <= dl_q;
              if (rd_q && dum_q != `DUMMY_NONE) st_q <= S_DUMMY;
              else if (rd_q) st_q <= S_OUT;                      // see R10
              else if (prog_q) st_q <= S_IN;
              else st_q <= S_END;
            end
          end
          S_DUMMY: begin
            pos_q <= `POS_ZERO;
            cnt_q <= cnt_q + `CNT_ONE;
            if (cnt_q == dum_q - `CNT_ONE) st_q <= S_OUT;
          end
          S_IN: if (byte_done) begin
            wr_data_q <= in_byte;
            wr_valid_q <= prog_q;
            if (prog_q) cnt_q <= `CNT_ONE;
            else begin
              cnt_q <= cnt_q + `CNT_ONE;
              if (cnt_q == `CNT_ZERO) val0_q <= in_byte;         // see R16
              else val1_q <= in_byte;
              if (cnt_q == nval_q - `CNT_ONE) st_q <= S_END;
            end
          end
          S_END: st_q <= S_STBY;                                 // see R21
          S_OUT: pos_q <= pos_q;
          default: st_q <= S_STBY;
        endcase
      end else if (fall && st_q == S_OUT) begin
        drive_q <= 1'b1;
        pos_q <= pos_q + lanes_q;
        out_sh_q <= nb << lanes_q;
        case (lanes_q)
          `LANES_4: io_q <= nb[7:4];
          `LANES_2: io_q <= {2'b00, nb[7:6]};
          default:  io_q <= {2'b00, nb[7], 1'b0};
        endcase
      end
    end
  end

  assign write_enable_latch_o = wel_q;
  assign burst_len_o = burst_q;
  assign hold_o      = hold_q;
  assign exec_valid_o = exec_q;
  assign exec_op_o   = op_q;
  assign addr_o      = addr_q;
  assign val0_o      = val0_q;
  assign val1_o      = val1_q;
  assign wr_data_o   = wr_data_q;
  assign wr_valid_o  = wr_valid_q;
  assign rd_req_o    = rd_req_q;
  assign rd_param_o  = (op_q == `OP_PARAM_TABLE_READ);
endmodule

// ===== core/sflash_consts.vh
/*
 * Constants of the serial flash command front end: opcodes, byte counts,
 * dummy cycle counts, lane widths and reset values.
 * Assumes it is included by bare name into the design file.
 */
`ifndef SFLASH_CONSTS_VH
`define SFLASH_CONSTS_VH

// array commands, then the parameter-table read
`define OP_NORMAL_READ         8'h03
`define OP_FAST_READ           8'h0b
`define OP_DUAL_ADDR_DATA_READ 8'hbb
`define OP_DUAL_OUTPUT_READ    8'h3b
`define OP_QUAD_ADDR_DATA_READ 8'heb
`define OP_QUAD_OUTPUT_READ    8'h6b
`define OP_PAGE_PROGRAM        8'h02
`define OP_QUAD_PAGE_PROGRAM   8'h38
`define OP_SECTOR_ERASE_4K     8'h20
`define OP_BLOCK_ERASE_32K     8'h52
`define OP_BLOCK_ERASE_64K     8'hd8
`define OP_CHIP_ERASE_A        8'h60
`define OP_CHIP_ERASE_B        8'hc7
`define OP_PARAM_TABLE_READ    8'h5a
// register and setting commands
`define OP_SET_WRITE_LATCH     8'h06
`define OP_CLEAR_WRITE_LATCH   8'h04
`define OP_STATUS_READ         8'h05
`define OP_CONFIG_READ         8'h15
`define OP_STATUS_CONFIG_WRITE 8'h01
`define OP_SUSPEND_A           8'h75
`define OP_SUSPEND_B           8'hb0
`define OP_RESUME_A            8'h7a
`define OP_RESUME_B            8'h30
`define OP_DEEP_SLEEP_ENTRY    8'hb9
`define OP_BURST_LENGTH_SET    8'hc0

// byte and cycle counts (cnt is 4 bits)
`define CNT_ZERO               4'h0
`define CNT_ONE                4'h1
`define ADDR_LAST              4'h2
`define VAL_NONE               4'h0
`define VAL_STATUS_CONFIG      4'h2
`define VAL_BURST              4'h1
`define DUMMY_NONE             4'h0
`define DUMMY_FAST             4'h8
`define DUMMY_DUAL_IO          4'h4
`define DUMMY_QUAD_IO          4'h6
`define DUMMY_PARAM            4'h8

// lane widths, as bits moved per serial clock
`define LANES_1                3'h1
`define LANES_2                3'h2
`define LANES_4                3'h4
`define POS_ZERO               3'h0

// reset values
`define BURST_LEN_RST          8'h00
`define ADDR_RST               24'h000000
`define BYTE_RST               8'h00

// read buffer
`define RDBUF_WIDTH            8
`define RDBUF_DEPTH            16
`define RDBUF_AW               4

`endif

// ===== tb/flash_host_model.sv
/* host side of the serial link: drives select, serial clock (mode 0), pause
   and data lanes. assumes the bench resolves the shared lanes into io_i. */
`timescale 1ns/1ns
module flash_host_model (
  // pins toward the device
  output logic       cs_n_o,
  output logic       sclk_o,
  output logic       hold_n_o,
  output logic [3:0] io_o,
  // resolved lane levels
  input  wire  [3:0] io_i
);
  initial begin
    cs_n_o   = 1'b1;
    sclk_o   = 1'b0;
    hold_n_o = 1'b1;
    io_o     = 4'h0;
  end
  // 125 ns period; lanes sampled at the rise, clock rests low between frames
  task automatic pulse(output logic [3:0] smp);
    #62 sclk_o = 1'b1;
    smp = io_i;
    #63 sclk_o = 1'b0;
  endtask
  // unused lanes flip so a stale level never reads as valid
  task automatic put(input logic [7:0] b, input int lanes);
    logic [3:0] s;
    logic [3:0] m;
    m = 4'((1 << lanes) - 1);
    for (int i = 8 - lanes; i >= 0; i -= lanes) begin
      io_o = (~io_o & ~m) | (4'(b >> i) & m);
      pulse(s);
    end
  endtask
  task automatic get(output logic [7:0] b, input int lanes);
    logic [3:0] s;
    b = 8'h00;
    for (int i = 0; i < 8; i += lanes) begin
      io_o = ~io_o;
      pulse(s);
      b = (lanes == 1) ? {b[6:0], s[1]} : 8'(b << lanes) | 8'(s & 4'((1 << lanes) - 1));
    end
  endtask
  task automatic junk(input int n);
    logic [3:0] s;
    repeat (n) begin
      io_o = ~io_o;
      pulse(s);
    end
  endtask
  // a new command always starts with pause released and select low
  task automatic sel();
    cs_n_o = 1'b0;
    #62;
  endtask
  // callers end on whole bytes unless they mean to break the boundary
  task automatic desel();
    #62 cs_n_o = 1'b1;
    #250;
  endtask
  task automatic hold(input logic lvl);
    hold_n_o = lvl;
    #100;
  endtask
endmodule

// ===== tb/sflash_hold_properties.sv
/* pause and command issue checks on the front end ports.
   assumes clk_i is much faster than the serial clock. */
`timescale 1ns/1ns
`include "sflash_consts.vh"
module sflash_hold_checker (
  // clock and reset
  input wire       clk_i,
  input wire       rstn_i,
  // watched ports
  input wire       cs_n_i,
  input wire       sclk_i,
  input wire       hold_n_i,
  input wire [3:0] io_oe_n_o,
  input wire       quad_mode_i,
  input wire       busy_i,
  input wire       write_enable_latch_o,
  input wire [7:0] burst_len_o,
  input wire       hold_o,
  input wire       exec_valid_o,
  input wire [7:0] exec_op_o,
  input wire [7:0] val0_o,
  input wire       rd_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_float; (!hold_n_i && !quad_mode_i) [*4] |-> io_oe_n_o == 4'hf; endproperty
  a_float: assert property (p_float) else $error("lanes driven in pause");
  property p_enter;
    $rose(hold_o) |-> !$past(hold_n_i) && !$past(cs_n_i) && !$past(sclk_i);
  endproperty
  a_enter: assert property (p_enter) else $error("bad pause entry");
  property p_leave; $fell(hold_o) && !cs_n_i |-> $past(hold_n_i) && !$past(sclk_i); endproperty
  a_leave: assert property (p_leave) else $error("bad pause exit");
  property p_quad; quad_mode_i [*3] |-> !hold_o; endproperty
  a_quad: assert property (p_quad) else $error("pause in quad mode");
  property p_held; hold_o |-> !exec_valid_o; endproperty
  a_held: assert property (p_held) else $error("command issued in pause");
  property p_set; exec_valid_o && exec_op_o == `OP_SET_WRITE_LATCH |-> write_enable_latch_o;
  endproperty
  a_set: assert property (p_set) else $error("latch not set");
  property p_clr;
    exec_valid_o && exec_op_o == `OP_CLEAR_WRITE_LATCH |-> ##[0:1] !write_enable_latch_o;
  endproperty
  a_clr: assert property (p_clr) else $error("latch not cleared");
  property p_burst;
    exec_valid_o && exec_op_o == `OP_BURST_LENGTH_SET |-> ##[0:1] burst_len_o == val0_o;
  endproperty
  a_burst: assert property (p_burst) else $error("burst length not stored");
  property p_pulse; exec_valid_o |-> $past(cs_n_i) ##1 !exec_valid_o; endproperty
  a_pulse: assert property (p_pulse) else $error("issue pulse off deselect");
  property p_busy; busy_i && $past(busy_i) |-> !rd_req_o; endproperty
  a_busy: assert property (p_busy) else $error("read while busy");
  c_pause: cover property (hold_o);
  c_burst: cover property (exec_valid_o && exec_op_o == `OP_BURST_LENGTH_SET);
  c_read: cover property (rd_req_o);
endmodule
bind serial_flash_command_hold sflash_hold_checker u_chk (.clk_i, .rstn_i, .cs_n_i, .sclk_i,
  .hold_n_i, .io_oe_n_o, .quad_mode_i, .busy_i, .write_enable_latch_o, .burst_len_o, .hold_o,
  .exec_valid_o, .exec_op_o, .val0_o, .rd_req_o);

// ===== tb/tb_top.sv
/* self-checking bench: a host model drives the pins, queues predict read bytes and collect program bytes, counters track issued
   commands. assumes the design and its header come first. */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic        clk_i, rstn_i, quad_mode_i, busy_i, wel_clr_i, rd_valid_i;
  logic [7:0]  status_i, config_i, rd_data_i, last_op, v;
  logic [23:0] a;
  wire         cs_n_i, sclk_i, hold_n_i, write_enable_latch_o, hold_o, exec_valid_o;
  wire         rd_req_o, rd_ready_o, rd_param_o, wr_valid_o;
  wire  [3:0]  h_io, io_o, io_oe_n_o, pin;
  wire  [7:0]  exec_op_o, burst_len_o, val0_o, val1_o, wr_data_o;
  wire  [23:0] addr_o;
  int          error_cnt, samples_checked, exec_n, rdreq_n, pushed, n;
  int          seed = 32'h7fcd7897;
  logic        took = 1'b0;
  logic [7:0]  fill_q[$], exp_q[$], wr_q[$];
  logic [7:0]  noarg[7] = '{8'h60, 8'hc7, 8'h75, 8'hb0, 8'h7a, 8'h30, 8'hb9};
  logic [7:0]  adr_ops[3] = '{8'h20, 8'h52, 8'hd8};
  assign pin = (io_oe_n_o & h_io) | (~io_oe_n_o & io_o);
  serial_flash_command_hold u_dut (.clk_i, .rstn_i, .cs_n_i, .sclk_i, .hold_n_i, .io_i(pin),
    .io_o, .io_oe_n_o, .quad_mode_i, .busy_i, .wel_clr_i, .status_i, .config_i,
    .write_enable_latch_o, .burst_len_o, .hold_o, .exec_valid_o, .exec_op_o, .addr_o, .val0_o,
    .val1_o, .wr_data_o, .wr_valid_o, .rd_req_o, .rd_param_o, .rd_data_i, .rd_valid_i,
    .rd_ready_o);
  flash_host_model u_host (.cs_n_o(cs_n_i), .sclk_o(sclk_i), .hold_n_o(hold_n_i), .io_o(h_io),
    .io_i(pin));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    took <= rd_valid_i & rd_ready_o;
    if (exec_valid_o) begin
      exec_n++;
      last_op = exec_op_o;
    end
    if (rd_req_o) rdreq_n++;
    if (wr_valid_o) wr_q.push_back(wr_data_o);
  end
  // read feeder: offers queued bytes, pops on each accepted handshake
  always @(negedge clk_i) begin
    if (took) begin
      void'(fill_q.pop_front());
      pushed++;
    end
    rd_valid_i = fill_q.size() != 0;
    rd_data_i = rd_valid_i ? fill_q[0] : ~rd_data_i;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic frame(input logic [7:0] b[$], input int xb, input bit ok);
    int n0;
    n0 = exec_n;
    u_host.sel();
    foreach (b[i]) u_host.put(b[i], 1);
    u_host.junk(xb);
    u_host.desel();
    @(negedge clk_i);
    `CHK("issue count", n0 + ok, exec_n)
    if (ok) `CHK("opcode", b[0], last_op)
  endtask
  task automatic pause_chk();
    u_host.hold(1'b0);
    `CHK("pause flag", 1'b1, hold_o)
    `CHK("lane enables", 4'hf, io_oe_n_o)
    u_host.junk(3);
    u_host.hold(1'b1);
    `CHK("pause flag", 1'b0, hold_o)
  endtask
  task automatic rd(input logic [7:0] op, input int al, dm, dl, nb, input bit ps);
    int r0;
    a = 24'($random(seed));
    r0 = rdreq_n;
    pushed = 0;
    exp_q.delete();
    repeat (20) begin
      v = 8'($random(seed));
      fill_q.push_back(v);
      exp_q.push_back(v);
    end
    exp_q.push_back(8'h00);
    u_host.sel();
    u_host.put(op, 1);
    `CHK("fifo fill", 16, pushed)
    for (int i = 2; i >= 0; i--) u_host.put(a[i*8 +: 8], al);
    @(negedge clk_i);
    `CHK("read request", r0 + 1, rdreq_n)
    `CHK("read address", a, addr_o)
    `CHK("table read", op == 8'h5a, rd_param_o)
    u_host.junk(dm);
    for (int i = 0; i < nb; i++) begin
      u_host.get(v, dl);
      `CHK("read byte", exp_q[i], v)
      if (ps && i == 0) pause_chk();
    end
    u_host.desel();
    fill_q.delete();
  endtask
  initial begin
    {quad_mode_i, busy_i, wel_clr_i, rd_valid_i, rd_data_i} = '0;
    status_i = 8'($random(seed));
    config_i = 8'($random(seed));
    rstn_i = 1'b0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i) rstn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    `CHK("burst reset", 8'h00, burst_len_o)
    frame('{8'h06}, 0, 1);
    `CHK("latch", 1'b1, write_enable_latch_o)
    wel_clr_i = 1'b1;
    @(negedge clk_i) wel_clr_i = 1'b0;
    `CHK("latch", 1'b0, write_enable_latch_o)
    frame('{8'h06}, 0, 1);
    frame('{8'h04}, 0, 1);
    `CHK("latch", 1'b0, write_enable_latch_o)
    foreach (noarg[i]) frame('{noarg[i]}, 0, 1);
    foreach (adr_ops[i]) begin
      a = 24'($random(seed));
      frame('{adr_ops[i], a[23:16], a[15:8], a[7:0]}, 0, 1);
      `CHK("erase address", a, addr_o)
    end
    v = 8'($random(seed));
    frame('{8'h02, a[23:16], a[15:8], a[7:0], v}, 0, 1);
    `CHK("program byte", v, wr_q[$])
    u_host.sel();
    u_host.put(8'h38, 1);
    for (int i = 2; i >= 0; i--) u_host.put(a[i*8 +: 8], 4);
    u_host.put(~v, 4);
    u_host.desel();
    @(negedge clk_i);
    `CHK("quad program address", a, addr_o)
    `CHK("quad program byte", ~v, wr_q[$])
    `CHK("quad program op", 8'h38, last_op)
    frame('{8'h01, v, ~v}, 0, 1);
    `CHK("status value", v, val0_o)
    `CHK("config value", ~v, val1_o)
    frame('{8'hc0, ~v}, 0, 1);
    `CHK("burst length", ~v, burst_len_o)
    frame('{8'h06}, 3, 0);
    frame('{8'h77, 8'h06}, 0, 0);
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_i) {busy_i, status_i, config_i} = 17'($random(seed));
      u_host.sel();
      u_host.put(i ? 8'h15 : 8'h05, 1);
      repeat (2) begin
        u_host.get(v, 1);
        `CHK("register read", i ? config_i : status_i, v)
      end
      u_host.desel();
    end
    @(negedge clk_i) busy_i = 1'b1;
    n = rdreq_n;
    frame('{8'h03, 8'h12, 8'h34, 8'h56}, 0, 0);
    `CHK("busy read", n, rdreq_n)
    busy_i = 1'b0;
    n = exec_n;
    u_host.sel();
    u_host.put(8'h06, 1);
    u_host.hold(1'b0);
    u_host.desel();
    u_host.hold(1'b1);
    `CHK("abandoned", n, exec_n)
    @(negedge clk_i) quad_mode_i = 1'b1;
    u_host.sel();
    u_host.hold(1'b0);
    @(negedge clk_i);
    `CHK("quad pause", 1'b0, hold_o)
    u_host.hold(1'b1);
    u_host.desel();
    @(negedge clk_i) quad_mode_i = 1'b0;
    rd(8'h03, 1, 0, 1, 21, 0);
    rd(8'h0b, 1, 8, 1, 2, 1);
    rd(8'hbb, 2, 4, 2, 2, 0);
    rd(8'h3b, 1, 8, 2, 2, 0);
    rd(8'heb, 4, 6, 4, 2, 0);
    rd(8'h6b, 1, 8, 4, 2, 0);
    rd(8'h5a, 1, 8, 1, 2, 0);
    end_of_test();
  end
  initial begin
    #900000;
    error_cnt++;
    end_of_test();
  end
endmodule
